//--- logic/fpkn_consts.svh
// Constants for the front-panel key navigation block.
`ifndef FPKN_CONSTS_SVH
`define FPKN_CONSTS_SVH
`define FPKN_CLK_HZ        250000000
`define FPKN_TICK_NS       1000000
`define FPKN_MS_CYCLES     ((`FPKN_TICK_NS) / 4)
`define FPKN_SHORT_MS      1000
`define FPKN_LONG_MS       3000
`define FPKN_COMMIT_MS     3000
`define FPKN_DEBOUNCE_MS   10
`define FPKN_REPEAT_MS     200
`define FPKN_FAST_MS       50
`define FPKN_FAST_AFTER    5
`define FPKN_ADV_PASSWORD  16'hff57
`define FPKN_ITEM_SLOTS    5
`endif

//--- logic/fpkn_pkg.sv
// Types for the front-panel key navigation block.
package fpkn_pkg;
    typedef enum logic [2:0] {
        LVL_OPERATION,
        LVL_ADJUSTMENT,
        LVL_INITIAL,
        LVL_COMMS,
        LVL_ADVANCED,
        LVL_CALIBRATION
    } fpkn_level_e;
    typedef enum logic [3:0] {
        PF_RUN_STOP,
        PF_AUTO_MANUAL,
        PF_AUTOTUNE,
        PF_ALARM_LATCH_CANCEL,
        PF_MONITOR_ITEM,
        PF_DIGIT_SHIFT,
        PF_PID_UPDATE,
        PF_FILTER_ADJUST,
        PF_COOLING_ADJUST
    } fpkn_pf_e;
endpackage

//--- logic/fpkn_key_if.sv
// Interface carrying one debounced key with its hold time in milliseconds.
`timescale 1ns/1ps
`default_nettype none
interface fpkn_key_if;
    logic        level;
    logic        press;
    logic        release_ev;
    logic [15:0] held_ms;
    modport src (output level, output press, output release_ev, output held_ms);
    modport dst (input level, input press, input release_ev, input held_ms);
endinterface
`default_nettype wire

//--- logic/fpkn_key_timer.sv
// Key synchroniser, debouncer and hold-time counter.
`timescale 1ns/1ps
`default_nettype none
`include "fpkn_consts.svh"
module fpkn_key_timer (
    // Clock, reset and millisecond tick.
    input  wire logic ref_clk,
    input  wire logic nrst,
    input  wire logic ms_tick,
    // Raw pin, high while pressed.
    input  wire logic key_pin,
    // Debounced key.
    fpkn_key_if.src   key
);
    logic       sync_a;
    logic       sync_b;
    logic       stable;
    logic [3:0] bounce;

    // Two-stage synchroniser; only the second stage is read further on.
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
        end else begin
            sync_a <= key_pin;
            sync_b <= sync_a;
        end
    end

    // A change is accepted after it stays put for the debounce time.
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            bounce <= 4'h0;
            stable <= 1'b0;
        end else if (sync_b == stable) begin
            bounce <= 4'h0;
        end else if (ms_tick) begin
            if (bounce == 4'(`FPKN_DEBOUNCE_MS - 1)) begin
                stable <= sync_b;
                bounce <= 4'h0;
            end else begin
                bounce <= bounce + 4'h1;
            end
        end
    end

    // Hold time saturates, and survives the release pulse so its length can be judged.
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            key.held_ms <= 16'h0000;
        end else if (!stable) begin
            key.held_ms <= key.level ? key.held_ms : 16'h0000;
        end else if (ms_tick && key.held_ms != 16'hffff) begin
            key.held_ms <= key.held_ms + 16'h0001;
        end
    end

    // Edge pulses, one cycle each.
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            key.level      <= 1'b0;
            key.press      <= 1'b0;
            key.release_ev <= 1'b0;
        end else begin
            key.level      <= stable;
            key.press      <= stable && !key.level;
            key.release_ev <= !stable && key.level;
        end
    end
endmodule
`default_nettype wire

//--- logic/fpkn_nav.sv
// Front-panel key navigation: setting levels, parameter stepping and value edit.
`timescale 1ns/1ps
`default_nettype none
`include "fpkn_consts.svh"
module fpkn_nav #(
    // Cycles in one millisecond tick; a simulation may use a shorter figure.
    parameter int MS_CYCLES = `FPKN_MS_CYCLES
) (
    // Clock and reset.
    input  wire logic            ref_clk,
    input  wire logic            nrst,
    // Raw key pins, high while pressed.
    input  wire logic            level_key_pin,
    input  wire logic            mode_key_pin,
    input  wire logic            up_key_pin,
    input  wire logic            down_key_pin,
    input  wire logic            programmable_function_key_pin,
    // Configuration from the parameter store.
    input  wire logic [3:0]      pf_setting,
    input  wire logic            auto_manual_add,
    input  wire logic            init_protect_clear,
    input  wire logic            goto_advanced_req,
    input  wire logic            goto_comms_req,
    input  wire logic            goto_calib_req,
    input  wire logic [15:0]     load_value,
    input  wire logic            load_strobe,
    // Navigation state.
    output logic [2:0]           setting_level,
    output logic                 param_next,
    output logic                 param_prev,
    output logic                 display_flash,
    // Value editing.
    output logic [15:0]          edit_value,
    output logic [15:0]          committed_value,
    output logic                 commit_pulse,
    output logic [1:0]           edit_digit,
    // Control and programmable-key actions.
    output logic                 control_stopped,
    output logic                 manual_mode,
    output logic                 autotune_req,
    output logic                 alarm_latch_cancel,
    output logic [2:0]           monitor_item,
    output logic                 pf_aux_pulse
);
    fpkn_key_if k_lvl ();
    fpkn_key_if k_mode ();
    fpkn_key_if k_up ();
    fpkn_key_if k_dn ();
    fpkn_key_if k_pf ();

    logic [17:0] ms_div;
    logic        ms_tick;
    logic [11:0] idle_ms;
    logic        pending;
    logic [7:0]  rep_ms;
    logic [3:0]  rep_cnt;
    logic        lvl_long_done;
    logic        pf_long_done;
    logic        lvl_change;
    logic        step_up;
    logic        step_dn;
    fpkn_pkg::fpkn_level_e lvl;
    fpkn_pkg::fpkn_pf_e    pf_role;

    // Power of ten for the selected digit.
    function automatic logic [15:0] digit_weight(input logic [1:0] d);
        unique case (d)
            2'h0: digit_weight = 16'h0001;
            2'h1: digit_weight = 16'h000a;
            2'h2: digit_weight = 16'h0064;
            2'h3: digit_weight = 16'h03e8;
        endcase
    endfunction

    assign pf_role = fpkn_pkg::fpkn_pf_e'(pf_setting);

    // Free-running millisecond enable from the system clock.
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            ms_div  <= 18'h00000;
            ms_tick <= 1'b0;
        end else begin
            ms_tick <= (ms_div == 18'(MS_CYCLES - 1));
            ms_div  <= (ms_div == 18'(MS_CYCLES - 1)) ? 18'h00000 : ms_div + 18'h00001;
        end
    end

    fpkn_key_timer u_lvl (.ref_clk(ref_clk), .nrst(nrst), .ms_tick(ms_tick),
                          .key_pin(level_key_pin), .key(k_lvl.src));
    fpkn_key_timer u_mode (.ref_clk(ref_clk), .nrst(nrst), .ms_tick(ms_tick),
                           .key_pin(mode_key_pin), .key(k_mode.src));
    fpkn_key_timer u_up (.ref_clk(ref_clk), .nrst(nrst), .ms_tick(ms_tick),
                         .key_pin(up_key_pin), .key(k_up.src));
    fpkn_key_timer u_dn (.ref_clk(ref_clk), .nrst(nrst), .ms_tick(ms_tick),
                         .key_pin(down_key_pin), .key(k_dn.src));
    fpkn_key_timer u_pf (.ref_clk(ref_clk), .nrst(nrst), .ms_tick(ms_tick),
                         .key_pin(programmable_function_key_pin), .key(k_pf.src));

    // Level moves: short release toggles, long holds act while still held.
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            lvl           <= fpkn_pkg::LVL_OPERATION;
            lvl_long_done <= 1'b0;
            lvl_change    <= 1'b0;
        end else begin
            lvl_change <= 1'b0;
            if (k_lvl.press) begin
                lvl_long_done <= 1'b0;
            end
            if (k_lvl.release_ev && !lvl_long_done &&
                k_lvl.held_ms < 16'(`FPKN_SHORT_MS)) begin
                unique case (lvl)
                    fpkn_pkg::LVL_OPERATION: begin
                        lvl        <= fpkn_pkg::LVL_ADJUSTMENT;
                        lvl_change <= 1'b1;
                    end
                    fpkn_pkg::LVL_ADJUSTMENT: begin
                        lvl        <= fpkn_pkg::LVL_OPERATION;
                        lvl_change <= 1'b1;
                    end
                    default: ;
                endcase
            end else if (k_lvl.level && !lvl_long_done) begin
                if ((lvl == fpkn_pkg::LVL_OPERATION || lvl == fpkn_pkg::LVL_ADJUSTMENT) &&
                    k_lvl.held_ms >= 16'(`FPKN_LONG_MS)) begin
                    lvl           <= fpkn_pkg::LVL_INITIAL;
                    lvl_long_done <= 1'b1;
                    lvl_change    <= 1'b1;
                end else if (lvl != fpkn_pkg::LVL_OPERATION &&
                             lvl != fpkn_pkg::LVL_ADJUSTMENT &&
                             k_lvl.held_ms >= 16'(`FPKN_SHORT_MS)) begin
                    lvl           <= fpkn_pkg::LVL_OPERATION;
                    lvl_long_done <= 1'b1;
                    lvl_change    <= 1'b1;
                end
            end else if (lvl == fpkn_pkg::LVL_INITIAL) begin
                if (goto_advanced_req && init_protect_clear &&
                    committed_value == `FPKN_ADV_PASSWORD) begin
                    lvl        <= fpkn_pkg::LVL_ADVANCED;
                    lvl_change <= 1'b1;
                end else if (goto_comms_req) begin
                    lvl        <= fpkn_pkg::LVL_COMMS;
                    lvl_change <= 1'b1;
                end
            end else if (lvl == fpkn_pkg::LVL_ADVANCED && goto_calib_req) begin
                lvl        <= fpkn_pkg::LVL_CALIBRATION;
                lvl_change <= 1'b1;
            end
        end
    end

    // Flash while a level-key hold has reached one second.
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            display_flash <= 1'b0;
        end else begin
            display_flash <= k_lvl.level && k_lvl.held_ms >= 16'(`FPKN_SHORT_MS);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            setting_level <= 3'h0;
        end else begin
            setting_level <= 3'(lvl);
        end
    end

    // Mode key: short release steps forward, a one-second hold steps back.
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            param_next <= 1'b0;
            param_prev <= 1'b0;
        end else begin
            param_next <= k_mode.release_ev && k_mode.held_ms < 16'(`FPKN_SHORT_MS);
            param_prev <= k_mode.level && ms_tick &&
                          k_mode.held_ms == 16'(`FPKN_SHORT_MS);
        end
    end

    // Up/down repeat: first step on press, then slow repeats that speed up.
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            rep_ms  <= 8'h00;
            rep_cnt <= 4'h0;
        end else if (!(k_up.level || k_dn.level)) begin
            rep_ms  <= 8'h00;
            rep_cnt <= 4'h0;
        end else if (ms_tick) begin
            if (rep_ms == ((rep_cnt >= 4'(`FPKN_FAST_AFTER)) ?
                           8'(`FPKN_FAST_MS - 1) : 8'(`FPKN_REPEAT_MS - 1))) begin
                rep_ms  <= 8'h00;
                rep_cnt <= (rep_cnt == 4'hf) ? rep_cnt : rep_cnt + 4'h1;
            end else begin
                rep_ms <= rep_ms + 8'h01;
            end
        end
    end

    assign step_up = k_up.press || (k_up.level && ms_tick && rep_ms == 8'h00 && rep_cnt != 4'h0);
    assign step_dn = k_dn.press || (k_dn.level && ms_tick && rep_ms == 8'h00 && rep_cnt != 4'h0);

    // Edit buffer kept apart from the committed value until a trigger.
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            edit_value      <= 16'h0000;
            committed_value <= 16'h0000;
            pending         <= 1'b0;
            idle_ms         <= 12'h000;
            commit_pulse    <= 1'b0;
        end else begin
            commit_pulse <= 1'b0;
            if (load_strobe && !pending) begin
                edit_value      <= load_value;
                committed_value <= load_value;
            end else if (step_up || step_dn) begin
                edit_value <= step_up ? edit_value + digit_weight(edit_digit)
                                      : edit_value - digit_weight(edit_digit);
                pending    <= 1'b1;
                idle_ms    <= 12'h000;
            end else if (pending && (k_mode.press || lvl_change ||
                         idle_ms == 12'(`FPKN_COMMIT_MS))) begin
                committed_value <= edit_value;
                commit_pulse    <= 1'b1;
                pending         <= 1'b0;
            end else if (pending && ms_tick) begin
                idle_ms <= idle_ms + 12'h001;
            end
        end
    end

    // Programmable key dispatch by role.
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            edit_digit         <= 2'h0;
            control_stopped    <= 1'b0;
            manual_mode        <= 1'b0;
            autotune_req       <= 1'b0;
            alarm_latch_cancel <= 1'b0;
            monitor_item       <= 3'h0;
            pf_aux_pulse       <= 1'b0;
            pf_long_done       <= 1'b0;
        end else begin
            autotune_req       <= 1'b0;
            alarm_latch_cancel <= 1'b0;
            pf_aux_pulse       <= 1'b0;
            if (k_pf.press) begin
                pf_long_done <= 1'b0;
            end
            if (k_pf.release_ev && k_pf.held_ms < 16'(`FPKN_SHORT_MS)) begin
                unique case (pf_role)
                    fpkn_pkg::PF_DIGIT_SHIFT: edit_digit <= edit_digit + 2'h1;
                    fpkn_pkg::PF_MONITOR_ITEM: monitor_item <=
                        (monitor_item == 3'(`FPKN_ITEM_SLOTS - 1)) ? 3'h0 : monitor_item + 3'h1;
                    default: ;
                endcase
            end else if (k_pf.level && !pf_long_done && k_pf.held_ms >= 16'(`FPKN_SHORT_MS)) begin
                pf_long_done <= 1'b1;
                unique case (pf_role)
                    fpkn_pkg::PF_RUN_STOP: control_stopped <= !control_stopped;
                    fpkn_pkg::PF_AUTO_MANUAL:
                        if (auto_manual_add) manual_mode <= !manual_mode;
                    fpkn_pkg::PF_AUTOTUNE: autotune_req <= 1'b1;
                    fpkn_pkg::PF_ALARM_LATCH_CANCEL: alarm_latch_cancel <= 1'b1;
                    fpkn_pkg::PF_PID_UPDATE,
                    fpkn_pkg::PF_FILTER_ADJUST,
                    fpkn_pkg::PF_COOLING_ADJUST: pf_aux_pulse <= 1'b1;
                    default: ;
                endcase
            end
            if (lvl != fpkn_pkg::LVL_OPERATION && lvl != fpkn_pkg::LVL_ADJUSTMENT) begin
                control_stopped <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

//--- sim/fpkn_nav_asserts.sv
// Concurrent checks on the ports of the key navigation block.
`timescale 1ns/1ps
`default_nettype none
module fpkn_nav_asserts (
    // Clock and reset.
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    // Configuration inputs.
    input  wire logic [3:0]  pf_setting,
    input  wire logic        auto_manual_add,
    input  wire logic        init_protect_clear,
    input  wire logic        load_strobe,
    // Watched outputs.
    input  wire logic [2:0]  setting_level,
    input  wire logic        param_next,
    input  wire logic        param_prev,
    input  wire logic [15:0] edit_value,
    input  wire logic [15:0] committed_value,
    input  wire logic        commit_pulse,
    input  wire logic [1:0]  edit_digit,
    input  wire logic        control_stopped,
    input  wire logic        manual_mode,
    input  wire logic        autotune_req,
    input  wire logic [2:0]  monitor_item
);
    // One clock domain, so clocking and reset muting are shared by all checks.
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    // Level moves, stop forcing and the advanced-level gate.
    adj_from_op_a: assert property (
        $changed(setting_level) && setting_level == 3'h1 |-> $past(setting_level) == 3'h0)
        else $error("adjustment level entered from a wrong level");
    cfg_stop_a: assert property (
        setting_level >= 3'h2 |-> ##[0:2] control_stopped)
        else $error("configuration level without control stopped");
    adv_gate_a: assert property (
        $changed(setting_level) && setting_level == 3'h4
        |-> $past(init_protect_clear) && $past(committed_value) == 16'hff57)
        else $error("advanced level entered without its password");

    // Value commit: only a commit or a load may move the committed copy.
    commit_copy_a: assert property (
        commit_pulse |-> ##[0:1] committed_value == edit_value)
        else $error("commit did not copy the edited value");
    commit_only_a: assert property (
        $changed(committed_value)
        |-> commit_pulse || $past(commit_pulse) || $past(load_strobe) || $past(load_strobe, 2))
        else $error("committed value moved without a commit");

    // The forward stepping pulse is single and never comes with a back step.
    step_pulse_a: assert property (
        param_next |-> !param_prev ##1 !param_next)
        else $error("parameter step pulse malformed");

    // Digit moves forward by one only in the digit shift role; its wrap back to units is not checked.
    digit_step_a: assert property (
        $changed(edit_digit) && edit_digit != 2'h0
        |-> edit_digit == $past(edit_digit) + 2'h1 && $past(pf_setting) == 4'h5)
        else $error("edit digit moved out of order");

    // Monitor item range and programmable key roles gating their actions.
    item_range_a: assert property (
        monitor_item <= 3'h4)
        else $error("monitor item beyond the fifth slot");
    manual_gate_a: assert property (
        $rose(manual_mode) |-> $past(auto_manual_add) && $past(pf_setting) == 4'h1)
        else $error("manual mode entered without its settings");
    tune_gate_a: assert property (
        autotune_req |-> $past(pf_setting) == 4'h2)
        else $error("autotune requested in another role");

    // Main scenarios.
    cov_adj_c: cover property ($changed(setting_level) && setting_level == 3'h1);
    cov_commit_c: cover property (commit_pulse);
    cov_manual_c: cover property ($rose(manual_mode));
endmodule

bind fpkn_nav fpkn_nav_asserts u_chk (
    .ref_clk(ref_clk), .nrst(nrst), .pf_setting(pf_setting),
    .auto_manual_add(auto_manual_add), .init_protect_clear(init_protect_clear),
    .load_strobe(load_strobe), .setting_level(setting_level), .param_next(param_next),
    .param_prev(param_prev), .edit_value(edit_value), .committed_value(committed_value),
    .commit_pulse(commit_pulse), .edit_digit(edit_digit), .control_stopped(control_stopped),
    .manual_mode(manual_mode), .autotune_req(autotune_req), .monitor_item(monitor_item));
`default_nettype wire

//--- sim/fpkn_operator.sv
// Model of the operator pressing the front-panel keys.
`timescale 1ns/1ps
`default_nettype none
module fpkn_operator (
    // Clock.
    input  wire logic ref_clk,
    // Key pins, high while pressed.
    output logic      level_key_pin,
    output logic      mode_key_pin,
    output logic      up_key_pin,
    output logic      down_key_pin,
    output logic      programmable_function_key_pin
);
    logic [4:0] keys = 5'h00;

    // A released key contact is open, so its pin rests low.
    assign {programmable_function_key_pin, down_key_pin, up_key_pin, mode_key_pin,
            level_key_pin} = keys;

    // Keys change just after an edge, like any other driven input.
    task automatic set_key(input int k, input logic v);
        @(posedge ref_clk);
        #1;
        keys[k] = v;
    endtask
endmodule
`default_nettype wire

//--- sim/tb_top.sv
// Self-checking bench for the key navigation block.
`timescale 1ns/1ps
`default_nettype none
`include "fpkn_consts.svh"
module tb_top;
    // A shortened millisecond keeps the run short; the design is built with the same figure.
    localparam int MS = 4;
    localparam int LVL = 0, MODE = 1, UP = 2, DOWN = 3, PF = 4;
    logic        ref_clk, nrst, auto_manual_add, init_protect_clear, goto_advanced_req;
    logic        load_strobe, param_next, param_prev, display_flash, commit_pulse;
    logic        control_stopped, manual_mode, autotune_req, alarm_latch_cancel, pf_aux_pulse;
    logic        level_key_pin, mode_key_pin, up_key_pin, down_key_pin;
    logic        programmable_function_key_pin;
    logic [3:0]  pf_setting;
    logic [2:0]  setting_level, monitor_item;
    logic [1:0]  edit_digit;
    logic [15:0] load_value, edit_value, committed_value, v0;
    int          error_cnt = 0, total_checks = 0, n_next = 0, n_prev = 0, n_tune = 0;
    int          n_alarm = 0, n_aux = 0;

    fpkn_operator op (.ref_clk(ref_clk), .level_key_pin(level_key_pin),
        .mode_key_pin(mode_key_pin), .up_key_pin(up_key_pin), .down_key_pin(down_key_pin),
        .programmable_function_key_pin(programmable_function_key_pin));

    // Comms and calibration requests stay low; those levels are not entered here.
    fpkn_nav #(.MS_CYCLES(MS)) dut (.ref_clk(ref_clk), .nrst(nrst),
        .level_key_pin(level_key_pin),
        .mode_key_pin(mode_key_pin), .up_key_pin(up_key_pin), .down_key_pin(down_key_pin),
        .programmable_function_key_pin(programmable_function_key_pin),
        .pf_setting(pf_setting), .auto_manual_add(auto_manual_add),
        .init_protect_clear(init_protect_clear), .goto_advanced_req(goto_advanced_req),
        .goto_comms_req(1'b0), .goto_calib_req(1'b0), .load_value(load_value),
        .load_strobe(load_strobe), .setting_level(setting_level), .param_next(param_next),
        .param_prev(param_prev), .display_flash(display_flash), .edit_value(edit_value),
        .committed_value(committed_value), .commit_pulse(commit_pulse),
        .edit_digit(edit_digit), .control_stopped(control_stopped),
        .manual_mode(manual_mode), .autotune_req(autotune_req),
        .alarm_latch_cancel(alarm_latch_cancel),
        .monitor_item(monitor_item), .pf_aux_pulse(pf_aux_pulse));

    // Clock at 250 MHz.
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // One-cycle pulses are counted so a check never has to catch their exact cycle.
    always @(posedge ref_clk) begin
        if (param_next === 1'b1) n_next++;
        if (param_prev === 1'b1) n_prev++;
        if (autotune_req === 1'b1) n_tune++;
        if (alarm_latch_cancel === 1'b1) n_alarm++;
        if (pf_aux_pulse === 1'b1) n_aux++;
    end

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask

    task automatic wait_ms(input int n);
        repeat (n * MS) @(posedge ref_clk);
        #1;
    endtask

    // Press, hold, release, then allow 20 ms for debounce and the 1-2 cycle answer.
    task automatic tap(input int k, input int ms);
        op.set_key(k, 1'b1);
        wait_ms(ms);
        op.set_key(k, 1'b0);
        wait_ms(20);
    endtask

    task automatic load(input logic [15:0] v);
        @(posedge ref_clk);
        #1;
        load_value = v;
        load_strobe = 1'b1;
        @(posedge ref_clk);
        #1;
        load_strobe = 1'b0;
    endtask

    task automatic sc_level_short;
        tap(LVL, 5);
        check("level", 16'h0, 16'(setting_level));
        tap(LVL, 50);
        check("level", 16'h1, 16'(setting_level));
        tap(LVL, 50);
        check("level", 16'h0, 16'(setting_level));
    endtask

    task automatic sc_pf_roles;
        pf_setting = fpkn_pkg::PF_AUTOTUNE;
        tap(PF, 1100);
        check("autotune", 16'h1, 16'(n_tune));
        pf_setting = fpkn_pkg::PF_ALARM_LATCH_CANCEL;
        tap(PF, 1100);
        check("alarm_latch_cancel", 16'h1, 16'(n_alarm));
        pf_setting = fpkn_pkg::PF_PID_UPDATE;
        tap(PF, 1100);
        check("pf_aux_pulse", 16'h1, 16'(n_aux));
        pf_setting = fpkn_pkg::PF_MONITOR_ITEM;
        tap(PF, 50);
        tap(PF, 50);
        check("monitor_item", 16'h2, 16'(monitor_item));
        pf_setting = fpkn_pkg::PF_AUTO_MANUAL;
        tap(PF, 1100);
        check("manual_mode", 16'h0, 16'(manual_mode));
        auto_manual_add = 1'b1;
        tap(PF, 1100);
        check("manual_mode", 16'h1, 16'(manual_mode));
        pf_setting = fpkn_pkg::PF_RUN_STOP;
        tap(PF, 1100);
        check("control_stopped", 16'h1, 16'(control_stopped));
        tap(PF, 1100);
        check("control_stopped", 16'h0, 16'(control_stopped));
    endtask

    // Long holds: flash at one second, initial level at three, refusals inside it.
    task automatic sc_level_long;
        op.set_key(LVL, 1'b1);
        wait_ms(1020);
        check("display_flash", 16'h1, 16'(display_flash));
        wait_ms(2000);
        check("level", 16'h2, 16'(setting_level));
        check("control_stopped", 16'h1, 16'(control_stopped));
        op.set_key(LVL, 1'b0);
        wait_ms(20);
        tap(LVL, 50);
        check("level", 16'h2, 16'(setting_level));
        goto_advanced_req = 1'b1;
        wait_ms(1);
        goto_advanced_req = 1'b0;
        check("level", 16'h2, 16'(setting_level));
        tap(LVL, 1100);
        check("level", 16'h0, 16'(setting_level));
    endtask

    task automatic sc_mode;
        tap(MODE, 50);
        check("param_next", 16'h1, 16'(n_next));
        tap(MODE, 1100);
        check("param_prev", 16'h1, 16'(n_prev));
        check("param_next", 16'h1, 16'(n_next));
    endtask

    // Digit edit, commits by mode press and by idle time, then held repeat.
    task automatic sc_edit;
        pf_setting = fpkn_pkg::PF_DIGIT_SHIFT;
        load(16'h0000);
        tap(UP, 50);
        check("edit_value", 16'h0001, edit_value);
        check("committed_value", 16'h0000, committed_value);
        tap(PF, 50);
        check("edit_digit", 16'h1, 16'(edit_digit));
        tap(UP, 50);
        check("edit_value", 16'h000b, edit_value);
        for (int i = 2; i < 5; i++) begin
            tap(PF, 50);
            check("edit_digit", 16'(i % 4), 16'(edit_digit));
        end
        tap(MODE, 50);
        check("committed_value", 16'h000b, committed_value);
        tap(DOWN, 50);
        check("committed_value", 16'h000b, committed_value);
        wait_ms(3020);
        check("committed_value", 16'h000a, committed_value);
        v0 = edit_value;
        tap(UP, 1000);
        check("repeat", 16'h1, 16'(edit_value - v0 > 16'h2));
        tap(MODE, 50);
    endtask

    task automatic sc_advanced;
        load(16'hff57);
        init_protect_clear = 1'b1;
        tap(LVL, 3020);
        goto_advanced_req = 1'b1;
        wait_ms(1);
        goto_advanced_req = 1'b0;
        check("level", 16'h4, 16'(setting_level));
        check("control_stopped", 16'h1, 16'(control_stopped));
    endtask

    task automatic report_and_stop;
        $display("checks %0d, errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Reset for three cycles, then the scenarios in an order that keeps control running
    // until the run/stop role has been tried.
    initial begin
        nrst = 1'b0;
        pf_setting = fpkn_pkg::PF_DIGIT_SHIFT;
        {auto_manual_add, init_protect_clear, goto_advanced_req, load_strobe} = 4'h0;
        load_value = 16'h0000;
        repeat (3) @(posedge ref_clk);
        #1;
        nrst = 1'b1;
        sc_level_short();
        sc_mode();
        sc_pf_roles();
        sc_level_long();
        sc_edit();
        sc_advanced();
        report_and_stop();
    end
endmodule
`default_nettype wire
